/* File: verification/focb_overtemp_src.sv */
// Purpose: overtemperature source on the far side of the bank
// Assumes: active-high level inputs that rest low when no source drives them
// Notes: one register stage, like a board-level synchroniser
`timescale 1ns/1ps
module focb_overtemp_src (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic hot,
   input wire logic hot_on_5v,
   output logic overtemp_pin,
   output logic overtemp_5v_pin
);
   // steer the asserted level to the chosen pin; the other pin rests low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overtemp_pin <= 1'b0;
         overtemp_5v_pin <= 1'b0;
      end else begin
         overtemp_pin <= hot & ~hot_on_5v;
         overtemp_5v_pin <= hot & hot_on_5v;
      end
   end
endmodule : focb_overtemp_src

/* File: verification/tb.sv */
// Purpose: self-checking bench of the fan overtemperature bank
// Assumes: short step and fan_speed_input periods set through parameters
// Notes: apb master waits for pready, bounded only by the watchdog; strobe waits in gap stop after 100 cycles
`timescale 1ns/1ps
`include "focb_consts.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb import focb_pkg::*;;
   localparam int STEP = 10;
   localparam int SLOW = 40;
   localparam int FAST = 10;
   logic pclk, presetn, psel, penable, pwrite, hot, hot_on_5v, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic overtemp_pin, overtemp_5v_pin, full_fan_force, alert_pin_select;
   logic alert_n_out, alert_n_oe, irq, fan_speed_input_measure_strobe;
   logic [3:0] continuous_fan_speed_input;
   logic [7:0] fan_speed_input_pulses_sel;
   focb_byte_t v, lim;
   int n_fail, n_compared, k, g;
   focb_bank #(.STEP_CYCLES(STEP), .FAN_SPEED_INPUT_SLOW_CYCLES(SLOW), .FAN_SPEED_INPUT_FAST_CYCLES(FAST))
   focb_bank_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .overtemp_pin(overtemp_pin), .overtemp_5v_pin(overtemp_5v_pin),
      .full_fan_force(full_fan_force), .alert_pin_select(alert_pin_select),
      .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .irq(irq),
      .fan_speed_input_measure_strobe(fan_speed_input_measure_strobe), .continuous_fan_speed_input(continuous_fan_speed_input),
      .fan_speed_input_pulses_sel(fan_speed_input_pulses_sel));
   focb_overtemp_src focb_overtemp_src_inst (.pclk(pclk), .presetn(presetn), .hot(hot),
      .hot_on_5v(hot_on_5v), .overtemp_pin(overtemp_pin), .overtemp_5v_pin(overtemp_5v_pin));
   // clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   function automatic focb_byte_t dur_exp(input int n);
      return (n > 255) ? 8'hff : 8'(n);
   endfunction : dur_exp
   function automatic logic lim_hit(input int n, input focb_byte_t l);
      return (l == 8'h00) || (n > int'(l));
   endfunction : lim_hit
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [7:0] idx, input focb_byte_t e);
      apb(1'b0, idx, 32'h0);
      `CHK($sformatf("reg %h", idx), {24'h0, e}, rd)
   endtask : rchk
   task automatic heat(input logic v5, input int n);
      hot_on_5v <= v5;
      hot <= 1'b1;
      cyc(n);
      hot <= 1'b0;
      cyc(4);
   endtask : heat
   task automatic gap();
      int n;
      n = 0;
      while (fan_speed_input_measure_strobe !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      g = 0;
      do begin
         @(posedge pclk);
         g++;
      end while (fan_speed_input_measure_strobe !== 1'b1 && g < 100);
   endtask : gap
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      print_verdict();
   end
   // main sequence
   initial begin
      {psel, penable, pwrite, hot, hot_on_5v, presetn} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      n_fail = 0;
      n_compared = 0;
      void'($urandom(32'h794299af));
      cyc(2);
      presetn <= 1'b1;
      rchk(`FOCB_IDX_CFG3, 8'h00);
      rchk(`FOCB_IDX_DUR_STAT, 8'h00);
      rchk(`FOCB_IDX_DUR_LIMIT, 8'h00);
      rchk(`FOCB_IDX_PULSES, 8'h55);
      `CHK("pulses out", 8'h55, fan_speed_input_pulses_sel)
      apb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      // every pulse code in every field, then random
      for (int i = 0; i < 6; i++) begin
         v = (i < 4) ? {4{2'(i)}} : 8'($urandom);
         apb(1'b1, `FOCB_IDX_PULSES, {24'h0, v});
         rchk(`FOCB_IDX_PULSES, v);
         `CHK("pulses out", v, fan_speed_input_pulses_sel)
      end
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         apb(1'b1, `FOCB_IDX_CFG3, {24'h0, v});
         rchk(`FOCB_IDX_CFG3, v);
         `CHK("alert select", v[0], alert_pin_select)
         `CHK("continuous", v[7:4], continuous_fan_speed_input)
      end
      // fan_speed_input rate, slow then rapid
      apb(1'b1, `FOCB_IDX_CFG3, 32'h00);
      gap();
      gap();
      `CHK("slow period", SLOW, g)
      apb(1'b1, `FOCB_IDX_CFG3, 32'h08);
      gap();
      gap();
      `CHK("fast period", FAST, g)
      // zero limit: immediate event, full fan, alert pin
      apb(1'b1, `FOCB_IDX_CFG3, 32'h07);
      hot <= 1'b1;
      cyc(6);
      #1;
      `CHK("full fan", 1'b1, full_fan_force)
      `CHK("irq", 1'b1, irq)
      `CHK("alert oe", 1'b1, alert_n_oe)
      `CHK("alert level", 1'b0, alert_n_out)
      rchk(`FOCB_IDX_DUR_STAT, 8'h01);
      rchk(`FOCB_IDX_DUR_STAT, 8'h00);
      hot <= 1'b0;
      apb(1'b1, `FOCB_IDX_INT_STAT, 32'h20);
      cyc(2);
      #1;
      `CHK("irq cleared", 1'b0, irq)
      // masked timer event
      apb(1'b1, `FOCB_IDX_INT_MASK, 32'h20);
      heat(1'b0, 6);
      #1;
      `CHK("masked irq", 1'b0, irq)
      `CHK("masked oe", 1'b0, alert_n_oe)
      apb(1'b0, `FOCB_IDX_INT_STAT, 32'h0);
      `CHK("timer status", 1'b1, rd[`FOCB_INT_TIMER])
      apb(1'b1, `FOCB_IDX_INT_MASK, 32'h00);
      cyc(2);
      #1;
      `CHK("unmasked irq", 1'b1, irq)
      apb(1'b0, `FOCB_IDX_DUR_STAT, 32'h0);
      // pin select and monitor enable
      apb(1'b1, `FOCB_IDX_CFG3, 32'h02);
      apb(1'b1, `FOCB_IDX_CFG4, 32'hf2);
      rchk(`FOCB_IDX_CFG4, 8'h02);
      heat(1'b0, 6);
      rchk(`FOCB_IDX_DUR_STAT, 8'h00);
      heat(1'b1, 6);
      rchk(`FOCB_IDX_DUR_STAT, 8'h01);
      apb(1'b1, `FOCB_IDX_CFG3, 32'h00);
      heat(1'b1, 6);
      rchk(`FOCB_IDX_DUR_STAT, 8'h00);
      apb(1'b1, `FOCB_IDX_CFG4, 32'h00);
      apb(1'b1, `FOCB_IDX_CFG3, 32'h02);
      // duration against limit, below and above
      for (int j = 0; j < 2; j++) begin
         k = $urandom_range(8, 3);
         lim = (j == 0) ? 8'(k + 2) : 8'(k - 1);
         apb(1'b1, `FOCB_IDX_DUR_LIMIT, {24'h0, lim});
         rchk(`FOCB_IDX_DUR_LIMIT, lim);
         apb(1'b1, `FOCB_IDX_INT_STAT, 32'h20);
         apb(1'b0, `FOCB_IDX_DUR_STAT, 32'h0);
         heat(1'b0, k * STEP + STEP / 2);
         rchk(`FOCB_IDX_DUR_STAT, dur_exp(k));
         apb(1'b0, `FOCB_IDX_INT_STAT, 32'h0);
         `CHK("limit event", lim_hit(k, lim), rd[`FOCB_INT_TIMER])
      end
      heat(1'b0, 260 * STEP);
      rchk(`FOCB_IDX_DUR_STAT, dur_exp(260));
      heat(1'b0, 6);
      rchk(`FOCB_IDX_DUR_STAT, 8'h01);
      // lock makes cfg3 and cfg4 read-only
      apb(1'b1, `FOCB_IDX_CFG1, 32'h02);
      apb(1'b1, `FOCB_IDX_CFG3, 32'hff);
      rchk(`FOCB_IDX_CFG3, 8'h02);
      apb(1'b1, `FOCB_IDX_CFG4, 32'h02);
      rchk(`FOCB_IDX_CFG4, 8'h00);
      print_verdict();
   end
endmodule : tb

/* File: verilog/focb_bank.sv */
// Purpose: configuration and status bank for fan overtemperature handling
// Assumes: APB slave, 32-bit data, byte address is four times the register index
// Notes: always ready, no wait states; unmapped addresses read zero with pslverr
//   only the duration timer event can set interrupt status, in bit 5
//   once set, the lock bit stays set until reset; it guards cfg1, cfg3 and cfg4
//   duration restarts at 0x01 on each new assertion; after release only a read changes it, clearing bit 0
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "focb_consts.svh"
module focb_bank
   import focb_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `FOCB_STEP_CYC,
   parameter int unsigned FAN_SPEED_INPUT_SLOW_CYCLES = `FOCB_FAN_SPEED_INPUT_SLOW_CYC,
   parameter int unsigned FAN_SPEED_INPUT_FAST_CYCLES = `FOCB_FAN_SPEED_INPUT_FAST_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic overtemp_pin,
   input wire logic overtemp_5v_pin,
   output logic full_fan_force,
   output logic alert_pin_select,
   output logic alert_n_out,
   output logic alert_n_oe,
   output logic irq,
   output logic fan_speed_input_measure_strobe,
   output logic [3:0] continuous_fan_speed_input,
   output logic [7:0] fan_speed_input_pulses_sel
);
   focb_byte_t cfg3_r, limit_r, pulses_r, cfg4_r, cfg1_r, int_stat_r, int_mask_r;
   logic [7:0] duration;
   logic [7:0] run_count;
   logic step_pulse;
   logic overtemp_active;
   logic prev_active_r;
   logic wr_en, rd_en, locked;
   logic [9:0] idx;
   logic timer_event;
   logic [31:0] fan_speed_input_cnt_r;
   logic over_limit_r;
   logic [31:0] rdata_nxt;
   logic err_nxt;
   logic irq_pending;

   // register index decode
   function automatic logic is_reg(input logic [9:0] a, input logic [7:0] reg_idx);
      return a == {2'b00, reg_idx};
   endfunction : is_reg

   assign idx = paddr[11:2];
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign locked = cfg1_r[`FOCB_CFG1_LOCK];

   // overtemperature input taken from the pin chosen by the select bit, gated by enable
   assign overtemp_active = cfg3_r[`FOCB_CFG3_MON_EN] &&
      (cfg4_r[`FOCB_CFG4_PIN_SEL] ? overtemp_5v_pin : overtemp_pin);

   // the input follows the chosen pin only while monitoring is enabled
   monitor_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg3_r[`FOCB_CFG3_MON_EN] |-> !overtemp_active)
      else $error("overtemp seen while monitoring off");
   fan_speed_input_pin_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg3_r[`FOCB_CFG3_MON_EN] && !cfg4_r[`FOCB_CFG4_PIN_SEL]) |->
      overtemp_active == overtemp_pin)
      else $error("overtemp not taken from fan_speed_input pin");
   supply_pin_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg3_r[`FOCB_CFG3_MON_EN] && cfg4_r[`FOCB_CFG4_PIN_SEL]) |->
      overtemp_active == overtemp_5v_pin)
      else $error("overtemp not taken from supply pin");

   // lock bit, itself written only while clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg1_r <= `FOCB_RST_CFG1;
      end else if (wr_en && is_reg(idx, `FOCB_IDX_CFG1) && !locked) begin
         cfg1_r <= pwdata[7:0];
      end
   end

   // a set lock cannot be undone by software
   lock_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
      locked |=> locked)
      else $error("lock bit cleared");

   // lockable configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg3_r <= `FOCB_RST_CFG3;
         cfg4_r <= `FOCB_RST_CFG4;
      end else if (wr_en && !locked) begin
         if (is_reg(idx, `FOCB_IDX_CFG3)) begin
            cfg3_r <= pwdata[7:0];
         end else if (is_reg(idx, `FOCB_IDX_CFG4)) begin
            cfg4_r <= pwdata[7:0] & `FOCB_CFG4_WMASK;
         end
      end
   end

   // unlocked write lands in the pin select register, unused bits dropped
   cfg4_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && !locked && is_reg(idx, `FOCB_IDX_CFG4)) |=>
      cfg4_r == ($past(pwdata[7:0]) & `FOCB_CFG4_WMASK))
      else $error("pin select write lost");

   // free configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         limit_r <= `FOCB_RST_LIMIT;
         pulses_r <= `FOCB_RST_PULSES;
         int_mask_r <= `FOCB_RST_MASK;
      end else if (wr_en) begin
         if (is_reg(idx, `FOCB_IDX_DUR_LIMIT)) begin
            limit_r <= pwdata[7:0];
         end else if (is_reg(idx, `FOCB_IDX_PULSES)) begin
            pulses_r <= pwdata[7:0];
         end else if (is_reg(idx, `FOCB_IDX_INT_MASK)) begin
            int_mask_r <= pwdata[7:0];
         end
      end
   end

   // limit and pulse writes always land
   limit_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && is_reg(idx, `FOCB_IDX_DUR_LIMIT)) |=> limit_r == $past(pwdata[7:0]))
      else $error("limit write lost");
   pulses_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && is_reg(idx, `FOCB_IDX_PULSES)) |=> pulses_r == $past(pwdata[7:0]))
      else $error("pulses write lost");

   // duration timer
   focb_duration_timer #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .overtemp_active(overtemp_active),
      .status_read(rd_en && is_reg(idx, `FOCB_IDX_DUR_STAT)),
      .duration_r(duration),
      .run_count_r(run_count),
      .step_pulse_r(step_pulse)
   );

   // asserted flag: restarts on a rise, cleared by a read when nothing sets it
   read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_en && is_reg(idx, `FOCB_IDX_DUR_STAT) && !(overtemp_active && !prev_active_r) &&
       !(overtemp_active && run_count >= 8'h02)) |=> !duration[0])
      else $error("asserted flag not cleared by read");
   rise_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
      (overtemp_active && !prev_active_r) |=> duration == 8'h01)
      else $error("duration not restarted at assertion");

   // limit event: zero limit fires at assertion, otherwise when count passes limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_active_r <= 1'b0;
         over_limit_r <= 1'b0;
      end else begin
         prev_active_r <= overtemp_active;
         over_limit_r <= 1'b0;
         if (overtemp_active && !prev_active_r && limit_r == 8'h00) begin
            over_limit_r <= 1'b1;
         end else if (overtemp_active && limit_r != 8'h00 && step_pulse &&
                      run_count == limit_r) begin
            over_limit_r <= 1'b1;
         end
      end
   end
   assign timer_event = over_limit_r;

   // count stepping past the limit reaches the status bit two cycles later
   limit_event_a: assert property (@(posedge pclk) disable iff (!presetn)
      (overtemp_active && limit_r != 8'h00 && step_pulse && run_count == limit_r) |=>
      ##1 int_stat_r[`FOCB_INT_TIMER])
      else $error("limit exceeded without event");

   // sticky status, write one to clear, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= 8'h00;
      end else begin
         if (wr_en && is_reg(idx, `FOCB_IDX_INT_STAT)) begin
            int_stat_r <= int_stat_r & ~pwdata[7:0];
         end
         if (timer_event) begin
            int_stat_r[`FOCB_INT_TIMER] <= 1'b1;
         end
      end
   end

   // status bit holds until a one is written to it
   sticky_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (int_stat_r[`FOCB_INT_TIMER] && !(wr_en && is_reg(idx, `FOCB_IDX_INT_STAT) &&
       pwdata[`FOCB_INT_TIMER])) |=> int_stat_r[`FOCB_INT_TIMER])
      else $error("timer status lost without clear");
   w1c_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && is_reg(idx, `FOCB_IDX_INT_STAT) && pwdata[`FOCB_INT_TIMER] && !timer_event)
      |=> !int_stat_r[`FOCB_INT_TIMER])
      else $error("timer status not cleared");

   // fan_speed_input measurement period strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fan_speed_input_cnt_r <= 32'h0;
         fan_speed_input_measure_strobe <= 1'b0;
      end else begin
         fan_speed_input_measure_strobe <= 1'b0;
         if (fan_speed_input_cnt_r >= (cfg3_r[`FOCB_CFG3_RAPID] ? FAN_SPEED_INPUT_FAST_CYCLES - 1 :
                            FAN_SPEED_INPUT_SLOW_CYCLES - 1)) begin
            fan_speed_input_cnt_r <= 32'h0;
            fan_speed_input_measure_strobe <= 1'b1;
         end else begin
            fan_speed_input_cnt_r <= fan_speed_input_cnt_r + 32'h1;
         end
      end
   end

   // strobe is a single-cycle pulse
   strobe_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
      fan_speed_input_measure_strobe |=> !fan_speed_input_measure_strobe)
      else $error("fan_speed_input strobe longer than one cycle");

   // any unmasked status bit, shared by irq and alert
   assign irq_pending = |(int_stat_r & ~int_mask_r);

   // registered control outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         full_fan_force <= 1'b0;
         alert_pin_select <= 1'b0;
         alert_n_out <= 1'b1;
         alert_n_oe <= 1'b0;
         irq <= 1'b0;
         continuous_fan_speed_input <= 4'h0;
         fan_speed_input_pulses_sel <= `FOCB_RST_PULSES;
      end else begin
         full_fan_force <= cfg3_r[`FOCB_CFG3_FULL_FAN] && overtemp_active;
         alert_pin_select <= cfg3_r[`FOCB_CFG3_ALERT];
         irq <= irq_pending;
         alert_n_out <= 1'b0;
         alert_n_oe <= cfg3_r[`FOCB_CFG3_ALERT] && irq_pending;
         continuous_fan_speed_input <= cfg3_r[7:`FOCB_CFG3_CONT_LSB];
         fan_speed_input_pulses_sel <= pulses_r;
      end
   end

   // control outputs follow their register bits one cycle later
   cont_fan_speed_input_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> continuous_fan_speed_input == $past(cfg3_r[7:`FOCB_CFG3_CONT_LSB]))
      else $error("continuous fan_speed_input bits not passed");
   full_fan_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(cfg3_r[`FOCB_CFG3_FULL_FAN] && overtemp_active) |=> !full_fan_force)
      else $error("full fan forced without cause");
   alert_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg3_r[`FOCB_CFG3_ALERT] && irq_pending) |=> alert_n_oe && !alert_n_out)
      else $error("alert not driven");

   // read mux
   always_comb begin
      rdata_nxt = 32'h0;
      err_nxt = 1'b0;
      if (is_reg(idx, `FOCB_IDX_CFG3)) begin
         rdata_nxt[7:0] = cfg3_r;
      end else if (is_reg(idx, `FOCB_IDX_DUR_STAT)) begin
         rdata_nxt[7:0] = duration;
      end else if (is_reg(idx, `FOCB_IDX_DUR_LIMIT)) begin
         rdata_nxt[7:0] = limit_r;
      end else if (is_reg(idx, `FOCB_IDX_PULSES)) begin
         rdata_nxt[7:0] = pulses_r;
      end else if (is_reg(idx, `FOCB_IDX_CFG4)) begin
         rdata_nxt[7:0] = cfg4_r;
      end else if (is_reg(idx, `FOCB_IDX_CFG1)) begin
         rdata_nxt[7:0] = cfg1_r;
      end else if (is_reg(idx, `FOCB_IDX_INT_STAT)) begin
         rdata_nxt[7:0] = int_stat_r;
      end else if (is_reg(idx, `FOCB_IDX_INT_MASK)) begin
         rdata_nxt[7:0] = int_mask_r;
      end else begin
         err_nxt = 1'b1;
      end
   end

   // apb answer: registered in setup, presented in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && err_nxt;
         prdata <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h0;
      end
   end

   // checks
   lock_blocks_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
      (locked && wr_en) |=> $stable(cfg3_r) && $stable(cfg4_r))
      else $error("locked config changed");
   full_fan_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
      (cfg3_r[2] && overtemp_active) |=> full_fan_force)
      else $error("full fan not forced");
   flag_on_assert_a: assert property (@(posedge pclk) disable iff (!presetn)
      (overtemp_active && !prev_active_r) |=> duration[0])
      else $error("asserted flag not set");
   zero_limit_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      (overtemp_active && !prev_active_r && limit_r == 8'h00) |=> ##1 int_stat_r[5])
      else $error("zero limit did not fire");
   early_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (run_count < 8'h02 && overtemp_active) |-> duration[7:1] == 7'h00)
      else $error("count moved early");
   saturate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (run_count == 8'hff && !(overtemp_active && !prev_active_r)) |=> run_count == 8'hff)
      else $error("count wrapped");
   mask_gates_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      int_mask_r[`FOCB_INT_TIMER] |=> !irq && !alert_n_oe)
      else $error("masked irq raised");
   alert_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg3_r[0] |=> !alert_n_oe && !alert_pin_select)
      else $error("alert driven while deselected");
   pulses_out_a: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> fan_speed_input_pulses_sel == $past(pulses_r))
      else $error("pulse fields not passed");
endmodule : focb_bank

/* File: verilog/focb_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts of the block
// Assumes: 50 MHz pclk, APB byte addressing of one register per word
// Notes: printed offsets are not all multiples of four, so they are kept as indices
`ifndef FOCB_CONSTS_SVH
`define FOCB_CONSTS_SVH
// register indices, byte address is four times the index
`define FOCB_IDX_CFG3 8'h78
`define FOCB_IDX_DUR_STAT 8'h79
`define FOCB_IDX_DUR_LIMIT 8'h7a
`define FOCB_IDX_PULSES 8'h7b
`define FOCB_IDX_CFG4 8'h7d
`define FOCB_IDX_CFG1 8'h40
`define FOCB_IDX_INT_STAT 8'h42
`define FOCB_IDX_INT_MASK 8'h75
// reset values
`define FOCB_RST_CFG3 8'h00
`define FOCB_RST_LIMIT 8'h00
`define FOCB_RST_PULSES 8'h55
`define FOCB_RST_CFG4 8'h00
`define FOCB_RST_CFG1 8'h00
`define FOCB_RST_MASK 8'h00
// field positions
`define FOCB_CFG3_ALERT 0
`define FOCB_CFG3_MON_EN 1
`define FOCB_CFG3_FULL_FAN 2
`define FOCB_CFG3_RAPID 3
`define FOCB_CFG3_CONT_LSB 4
`define FOCB_CFG4_PIN_SEL 1
`define FOCB_CFG1_LOCK 1
`define FOCB_INT_TIMER 5
`define FOCB_CFG4_WMASK 8'h0f
// timing, times in microseconds
`define FOCB_CLK_MHZ 50
`define FOCB_STEP_US 22760
`define FOCB_STEP_CYC (`FOCB_STEP_US * `FOCB_CLK_MHZ)
`define FOCB_FAN_SPEED_INPUT_SLOW_US 1000000
`define FOCB_FAN_SPEED_INPUT_FAST_US 250000
`define FOCB_FAN_SPEED_INPUT_SLOW_CYC (`FOCB_FAN_SPEED_INPUT_SLOW_US * `FOCB_CLK_MHZ)
`define FOCB_FAN_SPEED_INPUT_FAST_CYC (`FOCB_FAN_SPEED_INPUT_FAST_US * `FOCB_CLK_MHZ)
`endif

/* File: verilog/focb_duration_timer.sv */
// Purpose: times how long the overtemperature input stays asserted
// Assumes: overtemp input already qualified and synchronous to pclk
// Notes: one step per step_cycles clock cycles
`timescale 1ns/1ps
`include "focb_consts.svh"
module focb_duration_timer
   import focb_pkg::*;
#(
   parameter int unsigned STEP_CYCLES = `FOCB_STEP_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic overtemp_active,
   input wire logic status_read,
   output logic [7:0] duration_r,
   output logic [7:0] run_count_r,
   output logic step_pulse_r
);
   logic [31:0] prescale_r;
   logic prev_active_r;
   // prescaler restarts on each new assertion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_r <= 32'h0;
         step_pulse_r <= 1'b0;
         prev_active_r <= 1'b0;
      end else begin
         prev_active_r <= overtemp_active;
         step_pulse_r <= 1'b0;
         if (!overtemp_active || !prev_active_r) begin
            prescale_r <= 32'h0;
         end else if (prescale_r == STEP_CYCLES - 1) begin
            prescale_r <= 32'h0;
            step_pulse_r <= 1'b1;
         end else begin
            prescale_r <= prescale_r + 32'h1;
         end
      end
   end
   // step count of the current assertion, saturating
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_count_r <= 8'h00;
      end else if (overtemp_active && !prev_active_r) begin
         run_count_r <= 8'h00;
      end else if (step_pulse_r && run_count_r != 8'hff) begin
         run_count_r <= run_count_r + 8'h01;
      end
   end
   // reported duration: flag bit, then full count once two steps passed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duration_r <= 8'h00;
      end else if (overtemp_active && !prev_active_r) begin
         duration_r <= 8'h01;
      end else if (overtemp_active && run_count_r >= 8'h02) begin
         duration_r <= run_count_r;
      end else if (status_read) begin
         duration_r <= {duration_r[7:1], 1'b0};
      end
   end
endmodule : focb_duration_timer

/* File: verilog/focb_pkg.sv */
// Purpose: shared types of the fan overtemperature configuration bank
// Assumes: nothing
// Notes: constants live in focb_consts.svh
package focb_pkg;
   typedef logic [7:0] focb_byte_t;
   typedef enum logic [1:0] {FOCB_IDLE, FOCB_ACCESS} focb_apb_e;
endpackage : focb_pkg
